// ### ifs_words.sv
// Identify feature, transfer-mode and security status word generator.
// Function
// - Words 83 and 84 show bit 14 set and bit 15 clear.
// - Other bits of words 83 and 84 read as zero unless defined.
// - Word 82 bits 3, 12, 13, 14 set; bits 0,2,4,7-10 clear.
// - Word 82 bits 1, 5, 6 show security, write cache, look-ahead support.
// - Word 83 bits 0-2 and 4 clear; bit 3 shows power management support.
// - Word 87 shows bit 14 set, bit 15 clear, rest zero.
// - Word 85 mirrors the fixed supported bits of word 82.
// - Word 85 bits 1, 5, 6 show security, write cache, look-ahead enabled.
// - Word 86 bit 3 shows power management enabled; bits 0-2 and 4 clear.
// - Serial enabled word bits 1-6 mirror enabled link features; others zero.
// - Word 88 bits 8-14 flag at most one selected Ultra DMA mode.
// - Ultra DMA selection and multiword DMA selection never coexist.
// - Word 88 supported bits are cumulative from mode zero upward.
// - Word 88 reads zero when Ultra DMA is not supported.
// - Erase time word holds minutes divided by two when security supported.
// - Master password revision word holds the last recorded revision.
// - Security bit 8 set only when enabled at maximum level.
// - Expired count sets bit 4 and aborts unlock commands until reset.
// - Security word bits 0,1,2,3,5 show supported, enabled, locked, frozen, enhanced.
// - Security words are supplied whenever security is supported.
// - Field-validity word bit 2 marks word 88 as valid.
//
// The plain strobed port and the register addresses were left to the implementer.
`timescale 1ns/1ns
module ifs_words
  import ifs_pkg::*;
#(
  parameter logic [15:0] ERASE_TIME = 16'h000a,
  parameter logic [15:0] VALID_BASE = 16'h0003
) (
  // Clock and reset.
  input  wire logic        core_clk_i,
  input  wire logic        resetn_i,
  // Read port for identify words.
  input  wire logic [7:0]  addr_i,
  input  wire logic        rd_i,
  input  wire logic        wr_i,
  input  wire logic [15:0] wdata_i,
  output logic      [15:0] rdata_o,
  output logic             rvalid_o,
  // Live state of the drive.
  input  wire ifs_caps_t   caps_i,
  input  wire ifs_live_t   live_i,
  input  wire logic [15:0] mpw_rev_i,
  input  wire logic        mdma_sel_i,
  // Security count events and command gate.
  input  wire logic        count_expire_i,
  input  wire logic        unlock_cmd_i,
  output logic             cmd_abort_o,
  output logic             expired_o
);

  ifs_reg_t    r_ff;
  ifs_reg_t    nxt_r;
  logic [15:0] word;
  logic [6:0]  udma_sup_bits;
  logic [6:0]  udma_sel_bits;

  // Supported modes are a thermometer code up to the highest mode.
  always_comb begin
    for (int i = 0; i < 7; i++) begin
      udma_sup_bits[i] = caps_i.udma_sup && (3'(i) <= caps_i.udma_max);
      udma_sel_bits[i] = caps_i.udma_sup && live_i.udma_on && !mdma_sel_i
                         && (live_i.udma_mode == 3'(i));
    end
  end

  always_comb begin
    word = ZERO16;
    case (addr_i)
      W_VALID: begin
        word = VALID_BASE;
        word[B_UDMA_OK] = 1'b1;
      end
      W_SATA_EN: word = {9'h000, live_i.sata_en, 1'b0};
      W_SUP0: begin
        word = FIXED_FEAT;
        word[B_SECURITY]  = caps_i.sec_sup;
        word[B_WCACHE]    = caps_i.wcache_sup;
        word[B_LOOKAHEAD] = caps_i.look_sup;
      end
      W_SUP1: begin
        word = VALID_MARK;
        word[B_APM] = caps_i.apm_sup;
      end
      W_SUP2: word = VALID_MARK;
      W_EN0: begin
        word = FIXED_FEAT;
        word[B_SECURITY]  = caps_i.sec_sup && live_i.sec_en;
        word[B_WCACHE]    = caps_i.wcache_sup && live_i.wcache_en;
        word[B_LOOKAHEAD] = caps_i.look_sup && live_i.look_en;
      end
      W_EN1: word[B_APM] = caps_i.apm_sup && live_i.apm_en;
      W_EN2: word = VALID_MARK;
      W_UDMA: word = {1'b0, udma_sel_bits, 1'b0, udma_sup_bits};
      W_ERASE: word = caps_i.sec_sup ? ERASE_TIME : ZERO16;
      W_MPREV: word = caps_i.sec_sup ? mpw_rev_i : ZERO16;
      W_SEC: begin
        if (caps_i.sec_sup) begin
          word[S_SUP]     = 1'b1;
          word[S_EN]      = live_i.sec_en;
          word[S_LOCK]    = live_i.sec_lock;
          word[S_FROZEN]  = live_i.sec_frozen;
          word[S_ENH]     = caps_i.enh_erase_sup;
          word[S_EXPIRED] = r_ff.expired;
          word[S_MAXLVL]  = live_i.sec_en && live_i.sec_max;
        end
      end
      default: word = ZERO16;
    endcase
  end

  // The read answer is sampled from live state in the strobe cycle and shown one cycle after it.
  always_comb begin
    nxt_r = r_ff;
    nxt_r.rvalid = rd_i;
    if (rd_i) begin
      nxt_r.rdata = word;
    end
    nxt_r.state = rd_i ? IFS_ANSWER : IFS_IDLE;
    case (r_ff.state)
      IFS_IDLE:   nxt_r.abort = 1'b0;
      IFS_ANSWER: nxt_r.abort = 1'b0;
      default:    nxt_r.abort = 1'b0;
    endcase
    if (count_expire_i) begin
      nxt_r.expired = 1'b1;
    end
    nxt_r.abort = unlock_cmd_i && (r_ff.expired || count_expire_i);
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      r_ff <= '{state: IFS_IDLE, expired: 1'b0, rdata: ZERO16, rvalid: 1'b0, abort: 1'b0};
    end else begin
      r_ff <= nxt_r;
    end
  end

  assign rdata_o     = r_ff.rdata;
  assign rvalid_o    = r_ff.rvalid;
  assign cmd_abort_o = r_ff.abort;
  assign expired_o   = r_ff.expired;

  // The mask covers every bit of word 82 that has a fixed value except bits 11 and 15.
  property p_fixed82;
    @(posedge core_clk_i) disable iff (!resetn_i)
      rd_i && addr_i == W_SUP0 |=> (rdata_o & 16'h779d) == FIXED_FEAT;
  endproperty
  a_fixed82: assert property (p_fixed82) else $error("word 82 fixed bits wrong");

  property p_valid83;
    @(posedge core_clk_i) disable iff (!resetn_i)
      rd_i && (addr_i == W_SUP1 || addr_i == W_SUP2) |=> rdata_o[15:14] == 2'b01;
  endproperty
  a_valid83: assert property (p_valid83) else $error("valid mark missing");

  property p_en87;
    @(posedge core_clk_i) disable iff (!resetn_i)
      rd_i && addr_i == W_EN2 |=> rdata_o == VALID_MARK;
  endproperty
  a_en87: assert property (p_en87) else $error("word 87 wrong");

  property p_onehot;
    @(posedge core_clk_i) disable iff (!resetn_i)
      rd_i && addr_i == W_UDMA |=> $onehot0(rdata_o[14:8]);
  endproperty
  a_onehot: assert property (p_onehot) else $error("more than one mode");

  property p_mdma;
    @(posedge core_clk_i) disable iff (!resetn_i)
      rd_i && addr_i == W_UDMA && mdma_sel_i |=> rdata_o[14:8] == 7'h00;
  endproperty
  a_mdma: assert property (p_mdma) else $error("both dma kinds selected");

  property p_cumul;
    @(posedge core_clk_i) disable iff (!resetn_i)
      rd_i && addr_i == W_UDMA |=> ((rdata_o[6:0] + 7'h01) & rdata_o[6:0]) == 7'h00;
  endproperty
  a_cumul: assert property (p_cumul) else $error("modes not cumulative");

  property p_noudma;
    @(posedge core_clk_i) disable iff (!resetn_i)
      rd_i && addr_i == W_UDMA && !caps_i.udma_sup |=> rdata_o == ZERO16;
  endproperty
  a_noudma: assert property (p_noudma) else $error("word 88 not zero");

  property p_maxlvl;
    @(posedge core_clk_i) disable iff (!resetn_i)
      rd_i && addr_i == W_SEC && !live_i.sec_en |=> !rdata_o[S_MAXLVL];
  endproperty
  a_maxlvl: assert property (p_maxlvl) else $error("level bit while disabled");

  sequence s_expire;
    count_expire_i;
  endsequence
  sequence s_stay;
    expired_o [*8];
  endsequence
  property p_expired;
    @(posedge core_clk_i) disable iff (!resetn_i) s_expire |=> s_stay;
  endproperty
  a_expired: assert property (p_expired) else $error("expired not sticky");

  property p_abort;
    @(posedge core_clk_i) disable iff (!resetn_i)
      unlock_cmd_i && expired_o |=> cmd_abort_o;
  endproperty
  a_abort: assert property (p_abort) else $error("unlock not aborted");

  property p_secsup;
    @(posedge core_clk_i) disable iff (!resetn_i)
      rd_i && addr_i == W_SEC |=> rdata_o[S_SUP] == $past(caps_i.sec_sup);
  endproperty
  a_secsup: assert property (p_secsup) else $error("support bit wrong");

  property p_rvalid;
    @(posedge core_clk_i) disable iff (!resetn_i) rd_i |=> rvalid_o;
  endproperty
  a_rvalid: assert property (p_rvalid) else $error("answer missing");

  property p_opt82;
    @(posedge core_clk_i) disable iff (!resetn_i)
      rd_i && addr_i == W_SUP0 |=> rdata_o[B_SECURITY] == $past(caps_i.sec_sup)
        && rdata_o[B_WCACHE] == $past(caps_i.wcache_sup)
        && rdata_o[B_LOOKAHEAD] == $past(caps_i.look_sup);
  endproperty
  a_opt82: assert property (p_opt82) else $error("word 82 support bits wrong");

  property p_fixed85;
    @(posedge core_clk_i) disable iff (!resetn_i)
      rd_i && addr_i == W_EN0 |=> (rdata_o & 16'h779d) == FIXED_FEAT;
  endproperty
  a_fixed85: assert property (p_fixed85) else $error("word 85 fixed bits wrong");

  property p_opt85;
    @(posedge core_clk_i) disable iff (!resetn_i)
      rd_i && addr_i == W_EN0 |=>
        rdata_o[B_SECURITY] == ($past(caps_i.sec_sup) && $past(live_i.sec_en))
        && rdata_o[B_WCACHE] == ($past(caps_i.wcache_sup) && $past(live_i.wcache_en))
        && rdata_o[B_LOOKAHEAD] == ($past(caps_i.look_sup) && $past(live_i.look_en));
  endproperty
  a_opt85: assert property (p_opt85) else $error("word 85 enable bits wrong");

  property p_rsvd83;
    @(posedge core_clk_i) disable iff (!resetn_i)
      rd_i && addr_i == W_SUP1 |=> (rdata_o & 16'h3ff7) == ZERO16;
  endproperty
  a_rsvd83: assert property (p_rsvd83) else $error("word 83 reserved bits set");

  property p_apm83;
    @(posedge core_clk_i) disable iff (!resetn_i)
      rd_i && addr_i == W_SUP1 |=> rdata_o[B_APM] == $past(caps_i.apm_sup);
  endproperty
  a_apm83: assert property (p_apm83) else $error("word 83 power bit wrong");

  property p_rsvd84;
    @(posedge core_clk_i) disable iff (!resetn_i)
      rd_i && addr_i == W_SUP2 |=> rdata_o == VALID_MARK;
  endproperty
  a_rsvd84: assert property (p_rsvd84) else $error("word 84 reserved bits set");

  property p_en86;
    @(posedge core_clk_i) disable iff (!resetn_i)
      rd_i && addr_i == W_EN1 |=> (rdata_o & 16'hfff7) == ZERO16;
  endproperty
  a_en86: assert property (p_en86) else $error("word 86 stray bits set");

  property p_apm86;
    @(posedge core_clk_i) disable iff (!resetn_i)
      rd_i && addr_i == W_EN1 |=>
        rdata_o[B_APM] == ($past(caps_i.apm_sup) && $past(live_i.apm_en));
  endproperty
  a_apm86: assert property (p_apm86) else $error("word 86 power bit wrong");

  property p_rsvd79;
    @(posedge core_clk_i) disable iff (!resetn_i)
      rd_i && addr_i == W_SATA_EN |=> rdata_o[15:7] == 9'h000 && !rdata_o[0];
  endproperty
  a_rsvd79: assert property (p_rsvd79) else $error("serial word stray bits");

  property p_sata79;
    @(posedge core_clk_i) disable iff (!resetn_i)
      rd_i && addr_i == W_SATA_EN |=> rdata_o[6:1] == $past(live_i.sata_en);
  endproperty
  a_sata79: assert property (p_sata79) else $error("serial enable bits wrong");

  property p_rsvd88;
    @(posedge core_clk_i) disable iff (!resetn_i)
      rd_i && addr_i == W_UDMA |=> !rdata_o[15] && !rdata_o[7];
  endproperty
  a_rsvd88: assert property (p_rsvd88) else $error("word 88 reserved bits set");

  property p_valid53;
    @(posedge core_clk_i) disable iff (!resetn_i)
      rd_i && addr_i == W_VALID |=> rdata_o[B_UDMA_OK];
  endproperty
  a_valid53: assert property (p_valid53) else $error("word 88 not marked valid");

  property p_erase;
    @(posedge core_clk_i) disable iff (!resetn_i)
      rd_i && addr_i == W_ERASE && caps_i.sec_sup |=> rdata_o == ERASE_TIME;
  endproperty
  a_erase: assert property (p_erase) else $error("erase time word wrong");

  property p_mprev;
    @(posedge core_clk_i) disable iff (!resetn_i)
      rd_i && addr_i == W_MPREV && caps_i.sec_sup |=> rdata_o == $past(mpw_rev_i);
  endproperty
  a_mprev: assert property (p_mprev) else $error("password revision wrong");

  property p_secbits;
    @(posedge core_clk_i) disable iff (!resetn_i)
      rd_i && addr_i == W_SEC && caps_i.sec_sup |=> rdata_o[S_EN] == $past(live_i.sec_en)
        && rdata_o[S_LOCK] == $past(live_i.sec_lock)
        && rdata_o[S_FROZEN] == $past(live_i.sec_frozen);
  endproperty
  a_secbits: assert property (p_secbits) else $error("security state bits wrong");

  property p_rsvd128;
    @(posedge core_clk_i) disable iff (!resetn_i)
      rd_i && addr_i == W_SEC |=> (rdata_o & 16'hfec0) == ZERO16;
  endproperty
  a_rsvd128: assert property (p_rsvd128) else $error("security stray bits set");

  property p_expbit;
    @(posedge core_clk_i) disable iff (!resetn_i)
      rd_i && addr_i == W_SEC && caps_i.sec_sup |=> rdata_o[S_EXPIRED] == $past(expired_o);
  endproperty
  a_expbit: assert property (p_expbit) else $error("expired bit not shown");

  // An abort is only ever the answer to an unlock command.
  property p_abort_why;
    @(posedge core_clk_i) disable iff (!resetn_i)
      cmd_abort_o |-> $past(unlock_cmd_i);
  endproperty
  a_abort_why: assert property (p_abort_why) else $error("abort without command");

  property p_quiet;
    @(posedge core_clk_i) disable iff (!resetn_i)
      !rd_i |=> !rvalid_o;
  endproperty
  a_quiet: assert property (p_quiet) else $error("answer without read");

  property p_hold;
    @(posedge core_clk_i) disable iff (!resetn_i)
      !rd_i |=> $stable(rdata_o);
  endproperty
  a_hold: assert property (p_hold) else $error("read data moved without read");

  // No identify word is writable, so a write strobe must leave the read side alone.
  property p_nowrite;
    @(posedge core_clk_i) disable iff (!resetn_i)
      wr_i && !rd_i |=> !rvalid_o && $stable(rdata_o);
  endproperty
  a_nowrite: assert property (p_nowrite) else $error("write changed read side");
endmodule

// ### ifs_pkg.sv
// Package with word indices, bit positions and types for the identify feature words.
package ifs_pkg;
  localparam logic [7:0] W_VALID   = 8'h35;
  localparam logic [7:0] W_SATA_EN = 8'h4f;
  localparam logic [7:0] W_SUP0    = 8'h52;
  localparam logic [7:0] W_SUP1    = 8'h53;
  localparam logic [7:0] W_SUP2    = 8'h54;
  localparam logic [7:0] W_EN0     = 8'h55;
  localparam logic [7:0] W_EN1     = 8'h56;
  localparam logic [7:0] W_EN2     = 8'h57;
  localparam logic [7:0] W_UDMA    = 8'h58;
  localparam logic [7:0] W_ERASE   = 8'h59;
  localparam logic [7:0] W_MPREV   = 8'h5c;
  localparam logic [7:0] W_SEC     = 8'h80;
  localparam logic [15:0] VALID_MARK  = 16'h4000;
  localparam logic [15:0] FIXED_FEAT  = 16'h7008;
  localparam int          B_SECURITY  = 1;
  localparam int          B_WCACHE    = 5;
  localparam int          B_LOOKAHEAD = 6;
  localparam int          B_APM       = 3;
  localparam int          B_UDMA_OK   = 2;
  localparam int          UDMA_SEL_LO = 8;
  localparam int          S_SUP       = 0;
  localparam int          S_EN        = 1;
  localparam int          S_LOCK      = 2;
  localparam int          S_FROZEN    = 3;
  localparam int          S_EXPIRED   = 4;
  localparam int          S_ENH       = 5;
  localparam int          S_MAXLVL    = 8;
  localparam logic [15:0] ZERO16      = 16'h0000;
  localparam logic [15:0] ONES16      = 16'hffff;

  typedef enum logic [1:0] {IFS_IDLE, IFS_ANSWER} ifs_state_t;

  typedef struct packed {
    logic       sec_sup;
    logic       wcache_sup;
    logic       look_sup;
    logic       apm_sup;
    logic       enh_erase_sup;
    logic       udma_sup;
    logic [2:0] udma_max;
  } ifs_caps_t;

  typedef struct packed {
    logic       sec_en;
    logic       sec_lock;
    logic       sec_frozen;
    logic       sec_max;
    logic       wcache_en;
    logic       look_en;
    logic       apm_en;
    logic [5:0] sata_en;
    logic       udma_on;
    logic [2:0] udma_mode;
  } ifs_live_t;

  typedef struct packed {
    ifs_state_t  state;
    logic        expired;
    logic [15:0] rdata;
    logic        rvalid;
    logic        abort;
  } ifs_reg_t;
endpackage

// ### ifs_host.sv
// Host model that reads identify words from the drive.
`timescale 1ns/1ns
module ifs_host (
  // Clock.
  input  wire logic        core_clk_i,
  // Read port towards the drive.
  output logic      [7:0]  addr_o,
  output logic             rd_o,
  input  wire logic [15:0] rdata_i,
  input  wire logic        rvalid_i
);
  initial begin
    addr_o = 8'h00;
    rd_o   = 1'b0;
  end
  // Strobe for one cycle, then take the word in the cycle after it.
  task automatic rd_word(input logic [7:0] idx, output logic [15:0] w, output logic ok);
    @(posedge core_clk_i);
    rd_o   <= 1'b1;
    addr_o <= idx;
    @(posedge core_clk_i);
    rd_o   <= 1'b0;
    addr_o <= ~idx;
    #1;
    w  = rdata_i;
    ok = rvalid_i;
  endtask
  // All zeros or all ones in a feature word means no feature information.
  function automatic logic no_info(input logic [15:0] w);
    return (w === 16'h0000) || (w === 16'hffff);
  endfunction
endmodule

// ### test_identify_feature_security_words.sv
// Self-checking bench for the identify feature and security word generator.
`timescale 1ns/1ns
module test_identify_feature_security_words;
  import ifs_pkg::*;
  localparam logic [15:0] ERASE_T = 16'h0015;
  localparam logic [7:0] IDX [12] = '{W_VALID, W_SATA_EN, W_SUP0, W_SUP1, W_SUP2, W_EN0,
                                      W_EN1, W_EN2, W_UDMA, W_ERASE, W_MPREV, W_SEC};
  logic core_clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic [7:0] addr;
  logic rd, rvalid, mdma_sel = 1'b0, expire = 1'b0, unlock = 1'b0, abort, expired;
  logic [15:0] rdata, w, mpw_rev = 16'h1234;
  logic ok, exp_expired = 1'b0;
  ifs_caps_t caps = '0, caps_a, c;
  ifs_live_t live = '0, live_a, l;
  int fails = 0, n_checks = 0;
  always #4 core_clk_i = ~core_clk_i;
  ifs_host host (.core_clk_i(core_clk_i), .addr_o(addr), .rd_o(rd), .rdata_i(rdata),
                 .rvalid_i(rvalid));
  ifs_words #(.ERASE_TIME(ERASE_T)) dut (.core_clk_i(core_clk_i), .resetn_i(resetn_i),
    .addr_i(addr), .rd_i(rd), .wr_i(1'b0), .wdata_i(16'h0000), .rdata_o(rdata),
    .rvalid_o(rvalid), .caps_i(caps), .live_i(live), .mpw_rev_i(mpw_rev),
    .mdma_sel_i(mdma_sel), .count_expire_i(expire), .unlock_cmd_i(unlock),
    .cmd_abort_o(abort), .expired_o(expired));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [15:0] exp_word(input logic [7:0] idx);
    logic [15:0] sel;
    sel = (live.udma_on && !mdma_sel) ? (16'h0100 << live.udma_mode) : 16'h0000;
    case (idx)
      8'h35: return 16'h0007;
      8'h4f: return {9'h000, live.sata_en, 1'b0};
      8'h52: return 16'h7008 | {9'h000, caps.look_sup, caps.wcache_sup, 3'h0, caps.sec_sup, 1'b0};
      8'h53: return 16'h4000 | {12'h000, caps.apm_sup, 3'h0};
      8'h54, 8'h57: return 16'h4000;
      8'h55: return 16'h7008 | {9'h000, live.look_en, live.wcache_en, 3'h0, live.sec_en, 1'b0};
      8'h56: return {12'h000, live.apm_en, 3'h0};
      8'h58: return caps.udma_sup ? (sel | ((16'h0002 << caps.udma_max) - 16'h0001)) : 16'h0000;
      8'h59: return caps.sec_sup ? ERASE_T : 16'h0000;
      8'h5c: return caps.sec_sup ? mpw_rev : 16'h0000;
      8'h80: return caps.sec_sup ? {7'h00, live.sec_en & live.sec_max, 2'h0, caps.enh_erase_sup,
                     exp_expired, live.sec_frozen, live.sec_lock, live.sec_en, 1'b1} : 16'h0000;
      default: return 16'h0000;
    endcase
  endfunction
  task automatic setcfg(input ifs_caps_t cc, input ifs_live_t ll, input logic m);
    @(posedge core_clk_i);
    caps     <= cc;
    live     <= ll;
    mdma_sel <= m;
  endtask
  task automatic rd_chk(input logic [7:0] idx);
    host.rd_word(idx, w, ok);
    chk({15'h0000, ok}, 16'h0001);
    chk(w, exp_word(idx));
  endtask
  task automatic sweep(input string name);
    foreach (IDX[i]) begin
      rd_chk(IDX[i]);
      if (IDX[i] inside {W_SUP0, W_SUP1, W_SUP2, W_EN0, W_EN2}) begin
        chk({15'h0000, host.no_info(w)}, 16'h0000);
      end
    end
    rd_chk(8'h60);
    $display("test %s done", name);
  endtask
  // Bit 0 pulses the unlock command, bit 1 the count expiry.
  task automatic pulse(input logic [1:0] sel);
    @(posedge core_clk_i);
    unlock <= sel[0];
    expire <= sel[1];
    @(posedge core_clk_i);
    unlock <= 1'b0;
    expire <= 1'b0;
    #1;
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    #200000;
    fails++;
    conclude();
  end
  initial begin
    caps_a = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 3'h6};
    live_a = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 6'h2a, 1'b1, 3'h6};
    repeat (5) @(posedge core_clk_i);
    resetn_i <= 1'b1;
    #1;
    chk({13'h0000, rvalid, expired, abort}, 16'h0000);
    chk(rdata, ZERO16);
    setcfg(caps_a, live_a, 1'b0);
    sweep("full");
    setcfg('{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 3'h2},
           '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 6'h15, 1'b1, 3'h1}, 1'b1);
    sweep("bare");
    for (int m = 0; m < 8; m++) begin
      c = caps_a;
      l = live_a;
      c.udma_sup = (m < 7);
      c.udma_max = m[2:0];
      l.udma_mode = m[2:0];
      setcfg(c, l, 1'b0);
      rd_chk(W_UDMA);
    end
    $display("test udma done");
    setcfg(caps_a, live_a, 1'b0);
    pulse(2'b01);
    chk({15'h0000, abort}, 16'h0000);
    pulse(2'b10);
    exp_expired = 1'b1;
    chk({15'h0000, expired}, 16'h0001);
    pulse(2'b01);
    chk({15'h0000, abort}, 16'h0001);
    rd_chk(W_SEC);
    chk({15'h0000, abort}, 16'h0000);
    @(posedge core_clk_i);
    resetn_i <= 1'b0;
    @(posedge core_clk_i);
    resetn_i <= 1'b1;
    exp_expired = 1'b0;
    #1;
    chk({14'h0000, rvalid, expired}, 16'h0000);
    chk(rdata, ZERO16);
    rd_chk(W_SEC);
    pulse(2'b01);
    chk({15'h0000, abort}, 16'h0000);
    pulse(2'b11);
    exp_expired = 1'b1;
    chk({14'h0000, expired, abort}, 16'h0003);
    rd_chk(W_SEC);
    $display("test expiry done");
    conclude();
  end
endmodule
